// ===== arc_pkg.sv
// constants for the converter reset, power and serial configuration registers
package arc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses and word indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RST_PWR_B0 = 8'h04;
  localparam logic [7:0] ADDR_RST_PWR_B1 = 8'h05;
  localparam logic [7:0] ADDR_SDI_B0 = 8'h08;
  localparam logic [7:0] ADDR_SDO_B0 = 8'h0C;
  localparam logic [7:0] ADDR_SDO_B1 = 8'h0D;
  localparam logic [5:0] IDX_RST_PWR = 6'h01;
  localparam logic [5:0] IDX_SDI = 6'h02;
  localparam logic [5:0] IDX_SDO = 6'h03;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_SUPPLY_AL = 5;
  localparam int POS_INPUT_AL = 4;
  localparam int POS_RST_CLASS = 2;
  localparam int POS_LIGHT_SLEEP = 1;
  localparam int POS_POWER_DOWN = 0;
  localparam int POS_KEY = 8;
  localparam int POS_SYNC_CLK = 6;
  localparam int POS_GPO = 12;
  localparam int POS_SDO1 = 8;
  localparam int POS_GPO_IN_B1 = 4;

  // ----------------------------------------------------------------
  // key, reset values, encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] WRITE_KEY = 8'h69;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [1:0] MODE2_RESET = 2'h0;
  localparam logic [1:0] SDO1_TRISTATE = 2'h0;
  localparam logic [1:0] SDO1_ALARM = 2'h1;
  localparam logic [1:0] SDO1_GPO = 2'h2;
  localparam logic [1:0] SDO1_DUAL = 2'h3;
  localparam logic [1:0] SERIAL_OUTPUT_PROTOCOL_SEL_INVALID = 2'h2;
  localparam logic [1:0] SERIAL_OUTPUT_PROTOCOL_SEL_SRC = 2'h3;

  // ----------------------------------------------------------------
  // serial frame: command byte, address byte, data byte, msb first
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [4:0] BITS_HEADER = 5'h10;
  localparam logic [4:0] BITS_FRAME = 5'h18;

endpackage : arc_pkg

// ===== arc_regs.sv
// reset, power and serial configuration registers behind the serial port
//
// Overview of operation
// R1 - host writes 69h to 05h before register
// R2 - protected bits change only when key is 69h
// R3 - bit5 set disables supply alarm
// R4 - bit4 set disables input alarm
// R5 - reset pin: full init or modes only
// R6 - application reset class sticks until power cycle
// R7 - bit1 allows light sleep after conversion
// R8 - bit0 selects power down or active
// R9 - input protocol field selects spi polarity, phase
// R10 - reserved bits read zero, ignore writes
// R11 - registers split into bytes, low first
// R12 - output control field positions at 0Ch
// R13 - output mode: follow spi, source sync, invalid
// R14 - second pin: tristate, alarm, gpo, dual data
// R15 - sync clock source only in source sync
// R16 - unkeyed protected write silently ignored
`timescale 1ns/1ps
module arc_regs (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reset_pin_n_in,
  input wire logic serial_clock_in,
  input wire logic conversion_start_select_in,
  input wire logic serial_data_in,
  input wire logic conversion_busy_in,
  input wire logic alarm_in,
  input wire logic dual_data_bit_in,
  output logic first_data_out,
  output logic second_data_out,
  output logic second_data_oe_out,
  output logic supply_alarm_enable_out,
  output logic input_alarm_enable_out,
  output logic app_reset_class_out,
  output logic light_sleep_out,
  output logic power_down_out,
  output logic cpol_out,
  output logic cpha_out,
  output logic output_follows_spi_out,
  output logic source_sync_out,
  output logic output_mode_invalid_out,
  output logic sync_clock_internal_out,
  output logic dual_data_mode_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_sclk, sync_cs, sync_sdi, sync_rst;
  logic sclk_f, cs_f, rst_f, sclk_d;

  // three-stage chains, the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync_sclk <= 3'h0;
      sync_cs <= 3'h7;
      sync_sdi <= 3'h0;
      sync_rst <= 3'h7;
    end else begin
      sync_sclk <= {sync_sclk[1:0], serial_clock_in};
      sync_cs <= {sync_cs[1:0], conversion_start_select_in};
      sync_sdi <= {sync_sdi[1:0], serial_data_in};
      sync_rst <= {sync_rst[1:0], reset_pin_n_in};
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sclk_f <= 1'b0;
      cs_f <= 1'b1;
      rst_f <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      if (sync_sclk[1] == sync_sclk[2]) sclk_f <= sync_sclk[2];
      if (sync_cs[1] == sync_cs[2]) cs_f <= sync_cs[2];
      if (sync_rst[1] == sync_rst[2]) rst_f <= sync_rst[2];
      sclk_d <= sclk_f;
    end
  end

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  logic [7:0] key;
  logic supply_al_dis, input_al_dis, rst_class, light_sleep_en, power_down;
  logic app_latch;
  logic [1:0] serial_input_protocol_sel, serial_output_protocol_sel, sdo1_cfg;
  logic sync_clk_sel, general_output_value;

  // ----------------------------------------------------------------
  // serial frame decode
  // ----------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [23:0] rx_shift;
  logic [7:0] tx_shift;
  logic tx_skip;
  wire logic phase_lvl = sclk_f ^ serial_input_protocol_sel[1];  // [R9]
  wire logic phase_lvl_d = sclk_d ^ serial_input_protocol_sel[1];
  wire logic lead_edge = phase_lvl & ~phase_lvl_d;
  wire logic trail_edge = ~phase_lvl & phase_lvl_d;
  wire logic sample_edge = ~cs_f & (serial_input_protocol_sel[0] ? trail_edge : lead_edge);  // [R9]
  wire logic launch_edge = ~cs_f & (serial_input_protocol_sel[0] ? lead_edge : trail_edge);
  wire logic [23:0] rx_next = {rx_shift[22:0], sync_sdi[2]};
  wire logic frame_done = sample_edge && (bit_cnt == arc_pkg::BITS_FRAME - 5'h01);
  wire logic header_done = sample_edge && (bit_cnt == arc_pkg::BITS_HEADER - 5'h01);
  wire logic do_write = frame_done && (rx_next[23:16] == arc_pkg::CMD_WRITE);
  wire logic [7:0] wr_addr = rx_next[15:8];
  wire logic [7:0] wr_data = rx_next[7:0];
  wire logic key_ok = (key == arc_pkg::WRITE_KEY);  // [R2]
  wire logic pin_reset = ~rst_f;
  wire logic full_reset = sys_rst_in | (pin_reset & ~app_latch);  // [R5] [R6]
  wire logic app_reset = pin_reset & app_latch;  // [R5] [R6]

  // whole register word as read back, reserved bits zero
  function automatic logic [31:0] reg_word(input logic [5:0] idx);
    reg_word = 32'h0000_0000;  // [R10]
    unique case (idx)
      arc_pkg::IDX_RST_PWR: begin
        reg_word[arc_pkg::POS_KEY +: 8] = key;
        reg_word[arc_pkg::POS_SUPPLY_AL] = supply_al_dis;
        reg_word[arc_pkg::POS_INPUT_AL] = input_al_dis;
        reg_word[arc_pkg::POS_RST_CLASS] = rst_class;
        reg_word[arc_pkg::POS_LIGHT_SLEEP] = light_sleep_en;
        reg_word[arc_pkg::POS_POWER_DOWN] = power_down;
      end
      arc_pkg::IDX_SDI: reg_word[1:0] = serial_input_protocol_sel;
      arc_pkg::IDX_SDO: begin  // [R12]
        reg_word[arc_pkg::POS_GPO] = general_output_value;
        reg_word[arc_pkg::POS_SDO1 +: 2] = sdo1_cfg;
        reg_word[arc_pkg::POS_SYNC_CLK] = sync_clk_sel;
        reg_word[1:0] = serial_output_protocol_sel;
      end
      default: reg_word = 32'h0000_0000;
    endcase
  endfunction : reg_word

  // byte lane of a word, lowest address holds bits 7:0
  logic [31:0] rd_word;
  always_comb rd_word = reg_word(rx_next[7:2]);  // wakes on field changes too
  wire logic [7:0] rd_byte = rd_word[{rx_next[1:0], 3'h0} +: 8];  // [R11]

  // bit counter and receive shifter, cleared while select is high
  always_ff @(posedge clk_in) begin
    if (full_reset || cs_f) begin
      bit_cnt <= 5'h00;
      rx_shift <= 24'h00_0000;
    end else if (sample_edge) begin
      bit_cnt <= (bit_cnt == arc_pkg::BITS_FRAME - 5'h01) ? 5'h00 : bit_cnt + 5'h01;
      rx_shift <= rx_next;
    end
  end

  // read byte loaded after the header, first launch edge left alone
  always_ff @(posedge clk_in) begin
    if (full_reset || cs_f) begin
      tx_shift <= 8'h00;
      tx_skip <= 1'b0;
    end else if (header_done && rx_next[15:8] == arc_pkg::CMD_READ) begin
      tx_shift <= rd_byte;
      tx_skip <= 1'b1;
    end else if (launch_edge) begin
      tx_skip <= 1'b0;
      if (!tx_skip) tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // protected bits: class and light sleep bits survive application reset, key is cleared by it
  always_ff @(posedge clk_in) begin
    if (full_reset) begin
      key <= arc_pkg::KEY_RESET;
      supply_al_dis <= 1'b0;
      input_al_dis <= 1'b0;
      rst_class <= 1'b0;
      light_sleep_en <= 1'b0;
      power_down <= 1'b0;
    end else if (app_reset) begin
      key <= arc_pkg::KEY_RESET;
      supply_al_dis <= 1'b0;
      input_al_dis <= 1'b0;
      power_down <= 1'b0;
    end else if (do_write && wr_addr == arc_pkg::ADDR_RST_PWR_B1) begin
      key <= wr_data;  // [R1]
    end else if (do_write && wr_addr == arc_pkg::ADDR_RST_PWR_B0) begin
      key <= arc_pkg::KEY_RESET;
      if (key_ok) begin  // [R2] [R16]
        supply_al_dis <= wr_data[arc_pkg::POS_SUPPLY_AL];
        input_al_dis <= wr_data[arc_pkg::POS_INPUT_AL];
        rst_class <= wr_data[arc_pkg::POS_RST_CLASS];
        light_sleep_en <= wr_data[arc_pkg::POS_LIGHT_SLEEP];
        power_down <= wr_data[arc_pkg::POS_POWER_DOWN];
      end
    end
  end

  // sticky application class, cleared only by power-on reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) app_latch <= 1'b0;
    else if (do_write && wr_addr == arc_pkg::ADDR_RST_PWR_B0 && key_ok &&
             wr_data[arc_pkg::POS_RST_CLASS]) app_latch <= 1'b1;  // [R6]
  end

  // protocol fields kept through application reset
  always_ff @(posedge clk_in) begin
    if (full_reset) begin
      serial_input_protocol_sel <= arc_pkg::MODE2_RESET;
      serial_output_protocol_sel <= arc_pkg::MODE2_RESET;
      sync_clk_sel <= 1'b0;
    end else if (do_write && wr_addr == arc_pkg::ADDR_SDI_B0) begin
      serial_input_protocol_sel <= wr_data[1:0];  // [R9]
    end else if (do_write && wr_addr == arc_pkg::ADDR_SDO_B0) begin
      serial_output_protocol_sel <= wr_data[1:0];  // [R12]
      sync_clk_sel <= wr_data[arc_pkg::POS_SYNC_CLK];
    end
  end

  // second pin fields, cleared by either reset class
  always_ff @(posedge clk_in) begin
    if (full_reset || app_reset) begin
      sdo1_cfg <= arc_pkg::SDO1_TRISTATE;
      general_output_value <= 1'b0;
    end else if (do_write && wr_addr == arc_pkg::ADDR_SDO_B1) begin
      sdo1_cfg <= wr_data[1:0];  // [R12]
      general_output_value <= wr_data[arc_pkg::POS_GPO_IN_B1];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // control levels to the converter
  assign supply_alarm_enable_out = ~supply_al_dis;  // [R3]
  assign input_alarm_enable_out = ~input_al_dis;  // [R4]
  assign app_reset_class_out = app_latch;  // [R6]
  assign power_down_out = power_down;  // [R8]
  assign light_sleep_out = light_sleep_en & cs_f & ~conversion_busy_in & ~power_down;  // [R7]
  assign cpol_out = serial_input_protocol_sel[1];  // [R9]
  assign cpha_out = serial_input_protocol_sel[0];
  assign output_follows_spi_out = ~serial_output_protocol_sel[1];  // [R13]
  assign source_sync_out = (serial_output_protocol_sel == arc_pkg::SERIAL_OUTPUT_PROTOCOL_SEL_SRC);  // [R13]
  assign output_mode_invalid_out = (serial_output_protocol_sel == arc_pkg::SERIAL_OUTPUT_PROTOCOL_SEL_INVALID);  // [R13]
  assign sync_clock_internal_out = source_sync_out & sync_clk_sel;  // [R15]
  assign dual_data_mode_out = (sdo1_cfg == arc_pkg::SDO1_DUAL);  // [R14]

  // serial data pins
  assign first_data_out = tx_shift[7];
  assign second_data_oe_out = (sdo1_cfg != arc_pkg::SDO1_TRISTATE);  // [R14]
  assign second_data_out = (sdo1_cfg == arc_pkg::SDO1_ALARM) ? alarm_in :
                           (sdo1_cfg == arc_pkg::SDO1_GPO) ? general_output_value :
                           (sdo1_cfg == arc_pkg::SDO1_DUAL) ? dual_data_bit_in : 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_key_loaded;
    key_ok;
  endsequence
  sequence s_keyed_write;
    do_write && wr_addr == arc_pkg::ADDR_RST_PWR_B0 && !pin_reset;
  endsequence

  a_key_unlock: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R2]
    (s_keyed_write and s_key_loaded)
    |=> power_down == $past(wr_data[arc_pkg::POS_POWER_DOWN]))
    else $error("keyed write did not update power bit");
  a_unkeyed_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R16]
    (s_keyed_write and !key_ok) |=> $stable(power_down) && $stable(supply_al_dis))
    else $error("protected bits changed without key");
  a_key_consumed: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R2]
    s_keyed_write |=> key == arc_pkg::KEY_RESET)
    else $error("key not consumed by protected write");
  a_class_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R6]
    app_latch |=> app_latch)
    else $error("application class lost before power cycle");
  a_app_keeps_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R5]
    app_reset ##1 app_reset |-> $stable(serial_input_protocol_sel) && $stable(light_sleep_en))
    else $error("application reset cleared protocol fields");
  a_full_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R5]
    pin_reset && !app_latch |=> serial_input_protocol_sel == 2'h0 && !power_down && key == 8'h00)
    else $error("pin reset of power-on class left state");
  a_alarm_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R3]
    supply_alarm_enable_out != supply_al_dis && input_alarm_enable_out != input_al_dis)
    else $error("alarm enable does not follow disable bit");
  a_sleep_cond: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R7]
    light_sleep_out |-> light_sleep_en && cs_f && !conversion_busy_in)
    else $error("light sleep without enable or select high");
  a_second_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R14]
    sdo1_cfg == arc_pkg::SDO1_GPO |-> second_data_oe_out && second_data_out == general_output_value)
    else $error("second pin not driving gpo value");
  a_sync_clk: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R15]
    sync_clock_internal_out |-> serial_output_protocol_sel == arc_pkg::SERIAL_OUTPUT_PROTOCOL_SEL_SRC && sync_clk_sel)
    else $error("internal sync clock outside source sync");
  a_reserved_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [R10]
    rd_word[31:16] == 16'h0000 && (rx_next[7:2] != arc_pkg::IDX_SDI || rd_word[15:2] == 14'h0000))
    else $error("reserved bits read nonzero");

endmodule : arc_regs

// ===== arc_host.sv
// host controller model driving the serial port of the register block
`timescale 1ns/1ps
module arc_host (
  input wire logic clk_in,
  input wire logic first_data_in,
  output logic serial_clock_out,
  output logic select_out,
  output logic data_out
);
  localparam int HALF = 10; // clk cycles per serial clock phase
  logic cpol = 1'b0;
  logic cpha = 1'b0;

  // idle pins: select high, clock at its idle level
  initial begin
    serial_clock_out = 1'b0;
    select_out = 1'b1;
    data_out = 1'b0;
  end

  // one serial clock phase
  task automatic wt;
    repeat (HALF) @(posedge clk_in);
  endtask : wt

  // polarity and phase from the two-bit protocol code; clock idles at polarity
  task automatic set_mode(input logic [1:0] m);
    cpol = m[1];
    cpha = m[0];
    serial_clock_out <= m[1];
    wt();
  endtask : set_mode

  // one 24-bit frame, msb first; the last byte shifted out comes back in rdat
  task automatic xfer(input logic [23:0] bits, output logic [7:0] rdat);
    rdat = 8'h00;
    select_out <= 1'b0;
    wt();
    for (int i = 23; i >= 0; i--) begin
      if (!cpha) begin
        data_out <= bits[i];
        wt();
        if (i < 8) rdat = {rdat[6:0], first_data_in};
      end
      serial_clock_out <= ~cpol;
      if (cpha) data_out <= bits[i];
      wt();
      if (cpha && i < 8) rdat = {rdat[6:0], first_data_in};
      serial_clock_out <= cpol;
      if (cpha) wt();
    end
    wt();
    select_out <= 1'b1;
    data_out <= ~data_out; // released line does not keep its last value
    wt();
  endtask : xfer
endmodule : arc_host

// ===== arc_regs_test.sv
// self-checking bench for the reset, power and serial configuration registers
`timescale 1ns/1ps
module arc_regs_test;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reset_pin_n_in = 1'b1;
  logic conversion_busy_in = 1'b0;
  logic alarm_in = 1'b0;
  logic dual_data_bit_in = 1'b0;
  logic sclk, sel, mosi, first_data_out, second_data_out, second_data_oe_out;
  logic supply_alarm_enable_out, input_alarm_enable_out, app_reset_class_out;
  logic light_sleep_out, power_down_out, cpol_out, cpha_out, output_follows_spi_out;
  logic source_sync_out, output_mode_invalid_out, sync_clock_internal_out, dual_data_mode_out;
  logic [7:0] pwr_flags, mode_flags;
  int bad_count = 0;
  int compares = 0;

  // ------------------------------------------------------------
  // clock, instances, flag groups
  // ------------------------------------------------------------
  always #25 clk_in = ~clk_in;
  arc_host host (.clk_in(clk_in), .first_data_in(first_data_out), .serial_clock_out(sclk),
    .select_out(sel), .data_out(mosi));
  arc_regs uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reset_pin_n_in(reset_pin_n_in),
    .serial_clock_in(sclk), .conversion_start_select_in(sel), .serial_data_in(mosi),
    .conversion_busy_in(conversion_busy_in), .alarm_in(alarm_in),
    .dual_data_bit_in(dual_data_bit_in), .first_data_out(first_data_out),
    .second_data_out(second_data_out), .second_data_oe_out(second_data_oe_out),
    .supply_alarm_enable_out(supply_alarm_enable_out),
    .input_alarm_enable_out(input_alarm_enable_out), .app_reset_class_out(app_reset_class_out),
    .light_sleep_out(light_sleep_out), .power_down_out(power_down_out), .cpol_out(cpol_out),
    .cpha_out(cpha_out), .output_follows_spi_out(output_follows_spi_out),
    .source_sync_out(source_sync_out), .output_mode_invalid_out(output_mode_invalid_out),
    .sync_clock_internal_out(sync_clock_internal_out), .dual_data_mode_out(dual_data_mode_out));
  // packed views of the status outputs
  assign pwr_flags = {3'h0, supply_alarm_enable_out, input_alarm_enable_out,
    app_reset_class_out, light_sleep_out, power_down_out};
  assign mode_flags = {cpol_out, cpha_out, output_follows_spi_out, source_sync_out,
    output_mode_invalid_out, sync_clock_internal_out, dual_data_mode_out, second_data_oe_out};

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({arc_pkg::CMD_WRITE, a, d}, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host.xfer({arc_pkg::CMD_READ, a, 8'h00}, r);
    chk($sformatf("byte %h", a), exp, r);
  endtask : rd
  task automatic power_on;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : power_on
  task automatic pin_reset;
    reset_pin_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    reset_pin_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask : pin_reset
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    $display("[FAIL] run end expected done seen timeout");
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    power_on();
    chk("power flags", 8'h18, pwr_flags);
    chk("mode flags", 8'h20, mode_flags);
    for (int a = 4; a < 16; a++) rd(8'(a), 8'h00);
    rd(8'h10, 8'h00); // unmapped byte
    $display("test reset values done");
    wr(8'h04, 8'h3F);
    rd(8'h04, 8'h00);
    wr(8'h05, 8'h69);
    rd(8'h05, 8'h69);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h37);
    chk("power flags", 8'h05, pwr_flags);
    wr(8'h05, 8'h69);
    wr(8'h04, 8'h02);
    chk("power flags", 8'h1E, pwr_flags);
    conversion_busy_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("sleep while busy", 8'h1C, pwr_flags);
    conversion_busy_in <= 1'b0;
    $display("test key and power done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h0D, 8'h10 | 8'(c));
      rd(8'h0D, 8'h10 | 8'(c));
      chk("mode flags", {6'h08, c == 3, c != 0}, mode_flags);
      for (int k = 0; k < 2; k++) begin
        alarm_in <= k[0];
        dual_data_bit_in <= ~k[0];
        repeat (3) @(posedge clk_in);
        chk("second pin", {7'h0, c == 0 ? 1'b0 : c == 1 ? k[0] : c == 2 ? 1'b1 : ~k[0]},
          {7'h0, second_data_out});
      end
    end
    $display("test second pin done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h0C, 8'hC0 | 8'(m));
      rd(8'h0C, 8'h40 | 8'(m));
      chk("mode flags", {2'h0, m < 2, m == 3, m == 2, m == 3, 2'h3}, mode_flags);
    end
    $display("test output mode done");
    wr(8'h05, 8'h69);
    wr(8'h04, 8'h37);
    pin_reset();
    rd(8'h04, 8'h06);
    rd(8'h0D, 8'h00);
    rd(8'h0C, 8'h43);
    chk("power flags", 8'h1E, pwr_flags);
    $display("test application reset done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h08, 8'hFC | 8'(m));
      host.set_mode(2'(m));
      rd(8'h08, 8'(m));
      chk("mode flags", {2'(m), 6'h14}, mode_flags);
    end
    $display("test input protocol done");
    power_on();
    host.set_mode(2'h0);
    chk("power flags", 8'h18, pwr_flags);
    wr(8'h0D, 8'h13);
    wr(8'h0C, 8'h43);
    wr(8'h05, 8'h69);
    wr(8'h04, 8'h33);
    pin_reset();
    for (int a = 4; a < 16; a++) rd(8'(a), 8'h00);
    chk("power flags", 8'h18, pwr_flags);
    chk("mode flags", 8'h20, mode_flags);
    $display("test full reset done");
    complete_run();
  end
endmodule : arc_regs_test
